// ### inc/uasm_consts.svh
// Purpose: register offsets, field values and timing counts of the UART block
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one register per word
// Notes: control field positions follow the packed control struct in the package
`ifndef UASM_CONSTS_SVH
`define UASM_CONSTS_SVH

// Register byte offsets
`define UASM_OFS_CTRL 8'h00
`define UASM_OFS_BAUD 8'h04
`define UASM_OFS_TXD 8'h08
`define UASM_OFS_RXD 8'h0C
`define UASM_OFS_STAT 8'h10
`define UASM_OFS_IRQ 8'h14
`define UASM_OFS_MASK 8'h18

// Reset values
`define UASM_CTRL_W 18
`define UASM_CTRL_RST 18'h00000
`define UASM_BAUD_RST 8'h00
`define UASM_IRQ_RST 4'h0

// Interrupt status bit positions
`define UASM_IRQ_TX 0
`define UASM_IRQ_RX 1
`define UASM_IRQ_OVR 2
`define UASM_IRQ_FRM 3
`define UASM_IRQ_W 4

// Field encodings
`define UASM_FLOW_CTS 2'h1
`define UASM_FLOW_RTS 2'h2
`define UASM_PAR_NONE 2'h0
`define UASM_PAR_ODD 2'h1
`define UASM_LEN_9 2'h2

// Prescaler masks for the divide-by-1, 2, 8 and 32 taps
`define UASM_PRE_M1 5'h00
`define UASM_PRE_M2 5'h01
`define UASM_PRE_M8 5'h07
`define UASM_PRE_M32 5'h1F

// Oversampling: sixteen ticks per bit
`define UASM_OVS_LAST 4'hF
`define UASM_OVS_MID 4'h7
`define UASM_NBITS_MIN 4'h7
`define UASM_NBITS_MAX 4'h9

`endif

// ### inc/uasm_pkg.sv
// Purpose: shared types of the UART block
// Assumes: nothing beyond the constants header
// Notes: control struct is laid out LSB last, matching the control register
package uasm_pkg;

    // Control register, bit 0 is tx_enable_bit
    typedef struct packed {
        logic open_drain;
        logic split_cts_rts;
        logic tx_irq_source_select;
        logic pin_inv;
        logic data_inv;
        logic msb_first;
        logic two_stop;
        logic [1:0] parity;
        logic [1:0] char_len;
        logic [1:0] flow;
        logic [1:0] pre_sel;
        logic clock_source_select;
        logic rx_enable_bit;
        logic tx_enable_bit;
    } uasm_ctrl_t;

    // Latched AHB address phase
    typedef struct packed {
        logic vld;
        logic wr;
        logic [7:0] ofs;
    } uasm_ahb_ph_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uasm_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} uasm_rx_st_t;

endpackage

// ### src/uasm_baud.sv
// Purpose: 16x oversampling tick from prescaled or external clock
// Assumes: ext_lvl is already synchronised to clk
// Notes: tick rate is source / (divisor + 1), i.e. bit rate source / 16(n+1)
`timescale 1ns/10ps
`include "uasm_consts.svh"
module uasm_baud import uasm_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Source and divisor
    input wire logic clock_source_select,
    input wire logic [1:0] pre_sel,
    input wire logic ext_lvl,
    input wire logic [7:0] divisor,
    // Oversampling tick
    output logic tick16
);
    logic [4:0] pre_q;
    logic ext_q;
    logic [7:0] div_q;
    logic [4:0] pre_mask;
    logic src_en;

    // Prescaler tap select
    always_comb begin
        case (pre_sel)
            2'h0: pre_mask = `UASM_PRE_M1;
            2'h1: pre_mask = `UASM_PRE_M2;
            2'h2: pre_mask = `UASM_PRE_M8;
            default: pre_mask = `UASM_PRE_M32;
        endcase
    end

    // Internal taps or rising edges of the external clock feed the divider
    assign src_en = clock_source_select ? (ext_lvl & ~ext_q) : ((pre_q & pre_mask) == pre_mask);

    // Free running prescaler and edge history
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= 5'h00;
            ext_q <= 1'b0;
        end else begin
            pre_q <= 5'(pre_q + 5'h01);
            ext_q <= ext_lvl;
        end
    end

    // Reload divider; new divisor takes effect at the next reload
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 8'h00;
            tick16 <= 1'b0;
        end else begin
            tick16 <= src_en && (div_q == 8'h00);
            if (src_en) begin
                div_q <= (div_q == 8'h00) ? divisor : 8'(div_q - 8'h01);
            end
        end
    end
endmodule

// ### src/uasm_top.sv
// Purpose: asynchronous serial channel with AHB-Lite registers
// Assumes: 40 MHz clk; serial pins and external clock are asynchronous
// Notes: registers at CTRL 00, BAUD 04, TXD 08, RXD 0C, STAT 10, IRQ 14, MASK 18
`timescale 1ns/10ps
`include "uasm_consts.svh"
module uasm_top import uasm_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial pins
    input wire logic serial_in_pin,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n,
    input wire logic serial_clock_pin,
    // Flow control pins
    input wire logic cts_rts_pin_i,
    output logic cts_rts_pin_o,
    output logic cts_rts_pin_oe_n,
    input wire logic cts_sep_pin_n,
    // Interrupt
    output logic irq
);
    uasm_ctrl_t ctrl_q;
    uasm_ahb_ph_t ph_q;
    logic [7:0] baud_divisor_reg_q;
    logic [`UASM_IRQ_W-1:0] irq_st_q;
    logic [`UASM_IRQ_W-1:0] irq_mask_q;
    logic [`UASM_IRQ_W-1:0] irq_ev;
    logic [8:0] tx_buffer_reg_q;
    logic [8:0] rx_buffer_reg_q;
    logic tx_full_q;
    logic rx_full_q;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic tick;
    logic acc;
    logic rd_rx;
    logic [31:0] rd_mux;
    logic [3:0] nd;
    logic has_par;
    logic [8:0] dmask;
    logic [8:0] inv_m;
    logic cts_on;
    logic rts_on;
    logic cts_ok;
    logic rxl;
    uasm_tx_st_t tx_st_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [8:0] tx_sr_q;
    logic tx_par_q;
    logic txd_q;
    logic tx_go;
    logic tx_end;
    logic tx_fin;
    logic [8:0] tx_seq;
    uasm_rx_st_t rx_st_q;
    logic [3:0] rx_cnt_q;
    logic [3:0] rx_left_q;
    logic [3:0] rx_idx_q;
    logic [8:0] rx_sr_q;
    logic rx_bad_q;
    logic rx_ovr_q;
    logic rx_mid;
    logic rx_end;
    logic rx_fin;
    logic [8:0] rx_word;

    // Order bits as they travel on the line; same mapping both ways
    function automatic logic [8:0] uasm_order(input logic [8:0] d, input logic [3:0] n, input logic msb);
        logic [8:0] r;
        int j;
        r = d;
        if (msb) begin
            for (int i = 0; i < 9; i++) begin
                j = int'(n) - 1 - i;
                r[i] = (j >= 0) ? d[j[3:0]] : 1'b0;
            end
        end
        return r;
    endfunction

    // Data phase write hit
    function automatic logic wr_hit(input uasm_ahb_ph_t p, input logic [7:0] o);
        return p.vld && p.wr && (p.ofs == o);
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Frame shape from control
    assign nd = (ctrl_q.char_len == 2'h3) ? `UASM_NBITS_MAX : 4'(`UASM_NBITS_MIN + {2'h0, ctrl_q.char_len});
    assign has_par = (ctrl_q.parity != `UASM_PAR_NONE);
    assign dmask = 9'h1FF >> (`UASM_NBITS_MAX - nd);
    assign inv_m = {9{ctrl_q.data_inv}};

    // Pin synchronisers: rx data, ext clock, shared CTS, separate CTS
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
        end else begin
            sync1_q <= {cts_sep_pin_n, cts_rts_pin_i, serial_clock_pin, serial_in_pin};
            sync2_q <= sync1_q;
        end
    end

    assign rxl = sync2_q[0] ^ ctrl_q.pin_inv;
    // Split mode runs both functions, CTS on its own pin
    assign cts_on = (ctrl_q.flow == `UASM_FLOW_CTS) || ctrl_q.split_cts_rts;
    assign rts_on = (ctrl_q.flow == `UASM_FLOW_RTS) || ctrl_q.split_cts_rts;
    assign cts_ok = !cts_on || !(ctrl_q.split_cts_rts ? sync2_q[3] : sync2_q[2]);

    uasm_baud u_baud (
        .clk(clk),
        .rstn(rstn),
        .clock_source_select(ctrl_q.clock_source_select),
        .pre_sel(ctrl_q.pre_sel),
        .ext_lvl(sync2_q[1]),
        .divisor(baud_divisor_reg_q),
        .tick16(tick)
    );

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = hsel && htrans[1] && hready;
    assign rd_rx = acc && !hwrite && (haddr[7:0] == `UASM_OFS_RXD);

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (haddr[7:0])
            `UASM_OFS_CTRL: rd_mux = {14'h0000, ctrl_q};
            `UASM_OFS_BAUD: rd_mux = {24'h000000, baud_divisor_reg_q};
            `UASM_OFS_TXD: rd_mux = {23'h000000, tx_buffer_reg_q};
            `UASM_OFS_RXD: rd_mux = {23'h000000, rx_buffer_reg_q};
            `UASM_OFS_STAT: rd_mux = {28'h0000000, rx_st_q != RX_IDLE, tx_st_q != TX_IDLE, rx_full_q, !tx_full_q};
            `UASM_OFS_IRQ: rd_mux = {28'h0000000, irq_st_q};
            `UASM_OFS_MASK: rd_mux = {28'h0000000, irq_mask_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Address phase capture; read data sampled here so it stands in the data phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph_q <= '0;
            hrdata <= 32'h00000000;
        end else begin
            ph_q <= '{vld: acc, wr: hwrite, ofs: haddr[7:0]};
            hrdata <= (acc && !hwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= uasm_ctrl_t'(`UASM_CTRL_RST);
            baud_divisor_reg_q <= `UASM_BAUD_RST;
            irq_mask_q <= `UASM_IRQ_RST;
        end else begin
            if (wr_hit(ph_q, `UASM_OFS_CTRL)) begin
                ctrl_q <= uasm_ctrl_t'(hwdata[`UASM_CTRL_W-1:0]);
            end
            if (wr_hit(ph_q, `UASM_OFS_BAUD)) begin
                baud_divisor_reg_q <= hwdata[7:0];
            end
            if (wr_hit(ph_q, `UASM_OFS_MASK)) begin
                irq_mask_q <= hwdata[`UASM_IRQ_W-1:0];
            end
        end
    end

    // Transmit buffer; a write in the load cycle wins so it is not lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_buffer_reg_q <= 9'h000;
            tx_full_q <= 1'b0;
        end else if (wr_hit(ph_q, `UASM_OFS_TXD)) begin
            tx_buffer_reg_q <= hwdata[8:0];
            tx_full_q <= 1'b1;
        end else if (tx_go) begin
            tx_full_q <= 1'b0;
        end
    end

    // Transmit start and bit timing
    assign tx_go = (tx_st_q == TX_IDLE) && ctrl_q.tx_enable_bit && tx_full_q && cts_ok;
    assign tx_end = tick && (tx_cnt_q == `UASM_OVS_LAST);
    assign tx_fin = (tx_st_q == TX_STOP) && tx_end && (tx_bit_q == 4'h0);
    assign tx_seq = uasm_order((tx_buffer_reg_q ^ inv_m) & dmask, nd, ctrl_q.msb_first);

    // Transmit shifter; line level kept high outside start, data and parity
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_sr_q <= 9'h000;
            tx_par_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (tx_go) begin
            tx_st_q <= TX_START;
            tx_cnt_q <= 4'h0;
            tx_sr_q <= tx_seq;
            tx_par_q <= (^tx_seq) ^ (ctrl_q.parity == `UASM_PAR_ODD);
            txd_q <= 1'b0;
        end else if (tx_st_q != TX_IDLE && tick) begin
            tx_cnt_q <= 4'(tx_cnt_q + 4'h1);
            if (tx_end) begin
                case (tx_st_q)
                    TX_START: begin
                        tx_st_q <= TX_DATA;
                        txd_q <= tx_sr_q[0];
                        tx_sr_q <= tx_sr_q >> 1;
                        tx_bit_q <= 4'(nd - 4'h1);
                    end
                    TX_DATA: begin
                        if (tx_bit_q != 4'h0) begin
                            txd_q <= tx_sr_q[0];
                            tx_sr_q <= tx_sr_q >> 1;
                            tx_bit_q <= 4'(tx_bit_q - 4'h1);
                        end else if (has_par) begin
                            tx_st_q <= TX_PAR;
                            txd_q <= tx_par_q;
                        end else begin
                            tx_st_q <= TX_STOP;
                            txd_q <= 1'b1;
                            tx_bit_q <= {3'h0, ctrl_q.two_stop};
                        end
                    end
                    TX_PAR: begin
                        tx_st_q <= TX_STOP;
                        txd_q <= 1'b1;
                        tx_bit_q <= {3'h0, ctrl_q.two_stop};
                    end
                    TX_STOP: begin
                        if (tx_bit_q != 4'h0) begin
                            tx_bit_q <= 4'(tx_bit_q - 4'h1);
                        end else begin
                            tx_st_q <= TX_IDLE;
                        end
                    end
                    default: tx_st_q <= TX_IDLE;
                endcase
            end
        end
    end

    // Receive timing
    assign rx_mid = tick && (rx_cnt_q == `UASM_OVS_MID);
    assign rx_end = tick && (rx_cnt_q == `UASM_OVS_LAST);
    // Finish at mid last stop so a back-to-back start is not missed
    assign rx_fin = (rx_st_q == RX_BITS) && rx_mid && (rx_left_q == 4'h1);
    assign rx_word = uasm_order(rx_sr_q, nd, ctrl_q.msb_first) & dmask ^ (inv_m & dmask);

    // Receive shifter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= 4'h0;
            rx_left_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_sr_q <= 9'h000;
            rx_bad_q <= 1'b0;
            rx_ovr_q <= 1'b0;
        end else begin
            case (rx_st_q)
                RX_IDLE: begin
                    if (ctrl_q.rx_enable_bit && !rxl) begin
                        rx_st_q <= RX_START;
                        rx_cnt_q <= 4'h0;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        rx_cnt_q <= 4'(rx_cnt_q + 4'h1);
                    end
                    if (rx_mid && rxl) begin
                        rx_st_q <= RX_IDLE;
                    end else if (rx_end) begin
                        rx_st_q <= RX_BITS;
                        rx_left_q <= 4'(nd + {3'h0, has_par} + 4'h1 + {3'h0, ctrl_q.two_stop});
                        rx_idx_q <= 4'h0;
                        rx_sr_q <= 9'h000;
                        rx_bad_q <= 1'b0;
                        rx_ovr_q <= 1'b0;
                    end
                end
                RX_BITS: begin
                    if (tick) begin
                        rx_cnt_q <= 4'(rx_cnt_q + 4'h1);
                    end
                    if (rx_mid) begin
                        if (rx_idx_q < nd) begin
                            rx_sr_q[rx_idx_q] <= rxl;
                            rx_idx_q <= 4'(rx_idx_q + 4'h1);
                        end else if (rx_left_q <= {3'h0, ctrl_q.two_stop} + 4'h1 && !rxl) begin
                            rx_bad_q <= 1'b1;
                        end
                        if (rx_fin) begin
                            rx_st_q <= RX_IDLE;
                        end
                    end
                    if (rx_end) begin
                        rx_left_q <= 4'(rx_left_q - 4'h1);
                        if (rx_left_q == 4'h2 && rx_full_q) begin
                            rx_ovr_q <= 1'b1;
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer; overrun leaves the old word in place
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_buffer_reg_q <= 9'h000;
            rx_full_q <= 1'b0;
        end else if (rx_fin && !rx_ovr_q) begin
            rx_buffer_reg_q <= rx_word;
            rx_full_q <= 1'b1;
        end else if (rd_rx) begin
            rx_full_q <= 1'b0;
        end
    end

    // Events into sticky status
    assign irq_ev[`UASM_IRQ_TX] = ctrl_q.tx_irq_source_select ? tx_fin : tx_go;
    assign irq_ev[`UASM_IRQ_RX] = rx_fin && !rx_ovr_q;
    assign irq_ev[`UASM_IRQ_OVR] = rx_fin && rx_ovr_q;
    assign irq_ev[`UASM_IRQ_FRM] = rx_fin && (rx_bad_q || !rxl);

    // Write-one-to-clear; a same-cycle event wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_st_q <= `UASM_IRQ_RST;
        end else if (wr_hit(ph_q, `UASM_OFS_IRQ)) begin
            irq_st_q <= (irq_st_q & ~hwdata[`UASM_IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_st_q <= irq_st_q | irq_ev;
        end
    end

    // Pin drivers; open-drain releases the pin for a high level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_out_pin_o <= 1'b1;
            serial_out_pin_oe_n <= 1'b1;
            cts_rts_pin_o <= 1'b1;
            cts_rts_pin_oe_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            serial_out_pin_o <= txd_q ^ ctrl_q.pin_inv;
            serial_out_pin_oe_n <= ctrl_q.open_drain && (txd_q ^ ctrl_q.pin_inv);
            cts_rts_pin_o <= !(ctrl_q.rx_enable_bit && !rx_full_q);
            cts_rts_pin_oe_n <= !rts_on;
            irq <= |(irq_st_q & irq_mask_q);
        end
    end

    // Checks
    sequence s_tx_load;
        tx_st_q == TX_IDLE ##1 tx_st_q == TX_START;
    endsequence
    sequence s_rx_open;
        rx_st_q == RX_IDLE ##1 rx_st_q == RX_START;
    endsequence

    property p_tx_gate;
        s_tx_load |-> $past(ctrl_q.tx_enable_bit && tx_full_q && cts_ok);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("transmit started without its conditions");

    property p_rx_gate;
        s_rx_open |-> $past(ctrl_q.rx_enable_bit && !rxl);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("reception started without its conditions");

    property p_tx_irq_load;
        tx_go && !ctrl_q.tx_irq_source_select |=> irq_st_q[`UASM_IRQ_TX]
            && (!tx_full_q || $past(wr_hit(ph_q, `UASM_OFS_TXD))) ##1 (irq || !$past(irq_mask_q[`UASM_IRQ_TX]));
    endproperty
    a_tx_irq_load: assert property (p_tx_irq_load) else $error("no transmit event at load");

    property p_tx_irq_done;
        tx_fin && ctrl_q.tx_irq_source_select |=> irq_st_q[`UASM_IRQ_TX] && tx_st_q == TX_IDLE;
    endproperty
    a_tx_irq_done: assert property (p_tx_irq_done) else $error("no transmit event at end");

    property p_rx_irq;
        rx_fin && !rx_ovr_q |=> rx_full_q && irq_st_q[`UASM_IRQ_RX] && rx_buffer_reg_q == $past(rx_word);
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive transfer missing");

    property p_ovr_flag;
        rx_fin && rx_ovr_q |=> irq_st_q[`UASM_IRQ_OVR] && rx_buffer_reg_q == $past(rx_buffer_reg_q);
    endproperty
    a_ovr_flag: assert property (p_ovr_flag) else $error("overrun not flagged");

    property p_ovr_hold;
        rx_fin && rx_ovr_q && !irq_st_q[`UASM_IRQ_RX] |=> !irq_st_q[`UASM_IRQ_RX];
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overrun raised receive event");

    property p_frame;
        rx_fin && !rxl |=> irq_st_q[`UASM_IRQ_FRM];
    endproperty
    a_frame: assert property (p_frame) else $error("framing error missed");

    property p_idle_high;
        tx_st_q == TX_IDLE |-> txd_q;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");

    property p_pin;
        1'b1 |=> serial_out_pin_o == $past(txd_q ^ ctrl_q.pin_inv);
    endproperty
    a_pin: assert property (p_pin) else $error("pin level wrong");

    property p_bit16;
        tx_st_q == TX_START ##1 tx_st_q == TX_DATA |-> $past(tx_cnt_q) == `UASM_OVS_LAST;
    endproperty
    a_bit16: assert property (p_bit16) else $error("start bit not sixteen ticks");
endmodule

// ### bench/uasm_remote.sv
// Purpose: remote serial device model
// Assumes: 16 clocks per bit
// Notes: 8N1 frames only
`timescale 1ns/10ps
module uasm_remote (
    // Clock
    input wire logic clk,
    // Line from and to the device
    input wire logic line_in,
    output logic line_out
);
    // Idle high between frames
    initial line_out = 1'b1;
    // Start, data LSB first, stop of the chosen level
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (16) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask
    // Bounded hunt for start, then sample mid-bit
    task automatic recv(output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        while (line_in !== 1'b0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        ok = n < 500;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk);
            d[i] = line_in;
        end
    endtask
endmodule

// ### bench/uasm_top_tb.sv
// Purpose: self-checking bench of the UART channel
// Assumes: divisor 0, prescale /1
// Notes: remote model checks the wire
`timescale 1ns/10ps
module uasm_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, hreadyout, hresp, sin, sout, soe_n, rts, rts_oe_n, irq;
    logic cts = 1'b0, csep = 1'b1, eclk = 1'b0;
    int miscompares = 0, check_count = 0;
    // 40 MHz
    always #12.5 clk = ~clk;
    uasm_top dut (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .serial_in_pin(sin), .serial_out_pin_o(sout), .serial_out_pin_oe_n(soe_n),
        .serial_clock_pin(eclk), .cts_rts_pin_i(cts), .cts_rts_pin_o(rts), .cts_rts_pin_oe_n(rts_oe_n),
        .cts_sep_pin_n(csep), .irq(irq));
    uasm_remote far (.clk(clk), .line_in(sout), .line_out(sin));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One transfer; both phases wait for ready under a bound
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            while (hreadyout !== 1'b1 && n < 50) begin
                @(posedge clk);
                n++;
            end
            if (p == 0) begin
                htrans <= 2'h0;
                hwdata <= d;
            end
        end
        rv = hrdata;
        if (n >= 50) begin
            miscompares++;
            final_report();
        end
    endtask
    // Device sends, remote catches; then event, mask and clear
    task automatic tx_case(input logic [31:0] ctrl, input logic [7:0] d, exp, input logic [31:0] mid);
        logic [7:0] got;
        logic ok;
        bus(1'b1, 8'h00, ctrl);
        bus(1'b1, 8'h08, {24'h0, d});
        if (ctrl[6:5] == 2'h1 || ctrl[16]) begin
            repeat (40) @(posedge clk);
            chk("held", {30'h0, soe_n, sout}, 32'h1);
            chk("rtsoe", {31'h0, rts_oe_n}, {31'h0, !ctrl[16]});
            cts <= 1'b0;
            csep <= 1'b0;
        end
        far.recv(got, ok);
        chk("frame", {31'h0, ok}, 32'h1);
        if (!ok) final_report();
        chk("txdata", {24'h0, got}, {24'h0, exp});
        bus(1'b0, 8'h14, 32'h0);
        chk("txmid", rv, mid);
        repeat (40) @(posedge clk);
        bus(1'b0, 8'h14, 32'h0);
        chk("txend", rv, 32'h1);
        chk("masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h18, 32'h1);
        repeat (2) @(posedge clk);
        chk("unmasked", {31'h0, irq}, 32'h1);
        bus(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge clk);
        chk("cleared", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h18, 32'h0);
        $display("tx case done");
    endtask
    // External clock: no tick while the pin stands still, start bit ends on the sixteenth edge
    task automatic ext_case;
        bus(1'b1, 8'h00, 32'h85);
        bus(1'b1, 8'h08, 32'hFF);
        for (int i = 0; i < 16; i++) begin
            repeat (4) @(posedge clk);
            chk("extstart", {31'h0, sout}, 32'h0);
            eclk <= 1'b1;
            repeat (4) @(posedge clk);
            eclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        chk("extbit", {31'h0, sout}, 32'h1);
        bus(1'b1, 8'h00, 32'h81);
        repeat (200) @(posedge clk);
        bus(1'b1, 8'h14, 32'h1);
        $display("ext case done");
    endtask
    // Remote sends one or two frames; events and buffer judged
    task automatic rx_case(input logic [7:0] d, input logic stop, two, input logic [31:0] exp);
        bus(1'b1, 8'h00, 32'hC2);
        far.send(d, stop);
        if (two) begin
            @(posedge clk);
            far.send(d, 1'b1);
        end
        repeat (4) @(posedge clk);
        bus(1'b0, 8'h14, 32'h0);
        chk("rxirq", rv, exp);
        chk("rts", {30'h0, rts_oe_n, rts}, 32'h1);
        bus(1'b0, 8'h0C, 32'h0);
        chk("rxdata", rv, {24'h0, d});
        bus(1'b1, 8'h14, 32'hF);
        chk("rtsfree", {31'h0, rts}, 32'h0);
        $display("rx case done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("idle", {31'h0, sout}, 32'h1);
        tx_case(32'h81, 8'hA5, 8'hA5, 32'h1);
        tx_case(32'h1081, 8'h01, 8'h80, 32'h1);
        tx_case(32'h2081, 8'h0F, 8'hF0, 32'h1);
        tx_case(32'h8081, 8'h5A, 8'h5A, 32'h0);
        cts <= 1'b1;
        tx_case(32'hA1, 8'h3C, 8'h3C, 32'h1);
        csep <= 1'b1;
        tx_case(32'h10081, 8'h99, 8'h99, 32'h1);
        ext_case();
        rx_case(8'h3C, 1'b1, 1'b0, 32'h2);
        rx_case(8'h81, 1'b0, 1'b0, 32'hA);
        rx_case(8'h66, 1'b1, 1'b1, 32'h6);
        final_report();
    end
endmodule
